//--- logic/dew_eeprom_ctrl.sv
// Data EEPROM write controller with Avalon-MM register and array access
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps

// Function
// - Latch bit clear: array reads like ROM
// - Write mode: byte stored in addressed latch
// - Program bit written with latch bit: all written latches programmed together
// - Row from last write; one row per cycle
// - Cycle end clears program and latch together
// - Latches cleared at end/latch fall; AND merge
// - Latch contents never readable
// - Wait request: finish programming, then wait
// - Halt request: enter halt; abort at once from run, freeze from wait
// - Read in write mode: array returns zero, error flag set
// - Write in read mode: nothing latched, error flag set
// - Readout protection removal erases whole array
// - Program write protection never blocks array
// - Latch bit cleared by software only idle
// - Program bit reads one while busy
module dew_eeprom_ctrl
  import dew_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = DEW_PROG_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire dew_avreq_s  avReq,
  output logic [31:0]      avReadData,
  output logic             avWaitRequest,
  // Power requests from the core
  input  wire dew_pwrreq_s pwrReq,
  // Option bits
  input  wire logic        readoutProtectOption,
  input  wire logic        writeProtectOption,
  // Status
  output logic             irq,
  output logic             programBusy,
  output logic             eeWaitState,
  output logic             eeHaltState
);

  // ==========================================================================
  // State
  typedef struct packed
  {
    logic [DEW_CELLS-1:0][7:0]   cells;
    logic [DEW_LATCHES-1:0][7:0] latchData;
    logic [DEW_LATCHES-1:0]      latchValid;
    logic [DEW_ROW_W-1:0]        row;
    logic                        latchAccess;
    logic                        programStart;
    logic [31:0]                 cnt;
    dew_pwr_e                    pwr;
    logic                        ack;
    logic [31:0]                 rdata;
    logic [DEW_IRQ_W-1:0]        irqStatus;
    logic [DEW_IRQ_W-1:0]        irqMask;
    logic                        rpoPrev;
  } dew_state_s;

  dew_state_s s_r;
  dew_state_s s_nxt;

  // ==========================================================================
  // Helpers
  function automatic logic inArray(input logic [DEW_ADDR_W-1:0] a);
    inArray = ~a[DEW_AREA_BIT];
  endfunction

  function automatic logic [DEW_IDX_W-1:0] cellIdx(input logic [DEW_ADDR_W-1:0] a);
    cellIdx = a[DEW_IDX_W+1:2];
  endfunction

  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic                 evDone;
    logic                 evErr;
    logic                 evAbort;
    logic [DEW_IRQ_W-1:0] irqClr;
    logic [DEW_COL_W-1:0] col;
    logic [DEW_IDX_W-1:0] idx;
    evDone  = 1'b0;
    evErr   = 1'b0;
    evAbort = 1'b0;
    irqClr  = '0;
    idx     = cellIdx(avReq.address);
    col     = idx[DEW_COL_W-1:0];
    s_nxt   = s_r;

    // One wait state: data is registered before waitrequest drops
    s_nxt.ack     = (avReq.read | avReq.write) & ~s_r.ack;
    s_nxt.rpoPrev = readoutProtectOption;

    // Read capture in the first request cycle
    if (avReq.read && !s_r.ack)
    begin
      s_nxt.rdata = 32'h0000_0000;
      if (inArray(avReq.address))
      begin
        if (s_r.latchAccess)
          evErr = 1'b1;
        else
          s_nxt.rdata = {24'h00_0000, s_r.cells[idx]};
      end
      else
      begin
        case (avReq.address)
          DEW_OFS_CTRL:
          begin
            s_nxt.rdata[DEW_CTRL_LAT] = s_r.latchAccess;
            s_nxt.rdata[DEW_CTRL_PGM] = s_r.programStart;
          end
          DEW_OFS_IRQST:  s_nxt.rdata[DEW_IRQ_W-1:0] = s_r.irqStatus;
          DEW_OFS_IRQMSK: s_nxt.rdata[DEW_IRQ_W-1:0] = s_r.irqMask;
          DEW_OFS_STAT:
          begin
            s_nxt.rdata[DEW_STAT_WAIT] = (s_r.pwr == DEW_PWR_WAIT);
            s_nxt.rdata[DEW_STAT_HALT] = (s_r.pwr == DEW_PWR_HALT);
            s_nxt.rdata[DEW_STAT_WPO]  = writeProtectOption;
            s_nxt.rdata[DEW_STAT_RPO]  = readoutProtectOption;
          end
          default: s_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Writes take effect at the edge where waitrequest is low
    if (avReq.write && s_r.ack && avReq.byteenable[0])
    begin
      if (inArray(avReq.address))
      begin
        // Write protection of program memory plays no part here
        if (s_r.latchAccess)
        begin
          if (s_r.latchValid[col])
            s_nxt.latchData[col] = s_r.latchData[col] & avReq.writedata[7:0];
          else
            s_nxt.latchData[col] = avReq.writedata[7:0];
          s_nxt.latchValid[col] = 1'b1;
          s_nxt.row             = idx[DEW_IDX_W-1:DEW_COL_W];
        end
        else
          evErr = 1'b1;
      end
      else
      begin
        case (avReq.address)
          DEW_OFS_CTRL:
          begin
            if (avReq.writedata[DEW_CTRL_LAT])
              s_nxt.latchAccess = 1'b1;
            else if (!s_r.programStart && s_r.latchAccess)
            begin
              s_nxt.latchAccess = 1'b0;
              s_nxt.latchValid  = '0;
            end
            // Start from write mode or with the latch bit in the same write; clearing mid-cycle is ignored
            if (avReq.writedata[DEW_CTRL_PGM] && !s_r.programStart &&
                (s_r.latchAccess || avReq.writedata[DEW_CTRL_LAT]))
            begin
              s_nxt.programStart = 1'b1;
              s_nxt.latchAccess  = 1'b1;
              s_nxt.cnt          = 32'h0000_0000;
            end
          end
          DEW_OFS_IRQST:  irqClr        = avReq.writedata[DEW_IRQ_W-1:0];
          DEW_OFS_IRQMSK: s_nxt.irqMask = avReq.writedata[DEW_IRQ_W-1:0];
          default: ;
        endcase
      end
    end

    // Programming engine; frozen only in halt, which aborts it when entered from run but not from wait
    if (s_r.programStart && s_r.pwr != DEW_PWR_HALT)
    begin
      s_nxt.cnt = s_r.cnt + 32'h0000_0001;
      if (s_r.cnt >= PROG_LAST)
      begin
        for (int i = 0; i < DEW_LATCHES; i++)
        begin
          if (s_r.latchValid[i])
            s_nxt.cells[{s_r.row, DEW_COL_W'(i)}] = s_r.latchData[i];
        end
        s_nxt.programStart = 1'b0;
        s_nxt.latchAccess  = 1'b0;
        s_nxt.latchValid   = '0;
        s_nxt.cnt          = 32'h0000_0000;
        evDone             = 1'b1;
      end
    end

    // Power modes
    case (s_r.pwr)
      DEW_PWR_RUN:
      begin
        if (pwrReq.haltReq)
        begin
          s_nxt.pwr = DEW_PWR_HALT;
          if (s_r.programStart || s_nxt.programStart)
          begin
            // Row content is left as it was; no integrity promised
            s_nxt.programStart = 1'b0;
            s_nxt.latchAccess  = 1'b0;
            s_nxt.latchValid   = '0;
            s_nxt.cnt          = 32'h0000_0000;
            evAbort            = 1'b1;
          end
        end
        // Wait only one cycle after the last cycle has fully ended
        else if (pwrReq.waitReq && !s_r.programStart && !s_nxt.programStart)
          s_nxt.pwr = DEW_PWR_WAIT;
      end
      DEW_PWR_WAIT:
      begin
        if (pwrReq.haltReq)
          s_nxt.pwr = DEW_PWR_HALT;
        else if (!pwrReq.waitReq)
          s_nxt.pwr = DEW_PWR_RUN;
      end
      DEW_PWR_HALT:
      begin
        if (!pwrReq.haltReq)
          s_nxt.pwr = DEW_PWR_RUN;
      end
      default: s_nxt.pwr = DEW_PWR_RUN;
    endcase

    // Protection removal wipes the whole array and any pending cycle
    if (s_r.rpoPrev && !readoutProtectOption)
    begin
      for (int i = 0; i < DEW_CELLS; i++)
        s_nxt.cells[i] = DEW_ERASED;
      s_nxt.programStart = 1'b0;
      s_nxt.latchAccess  = 1'b0;
      s_nxt.latchValid   = '0;
      s_nxt.cnt          = 32'h0000_0000;
    end

    // Sticky flags; a new event wins over a same-cycle clear
    s_nxt.irqStatus = (s_r.irqStatus & ~irqClr);
    s_nxt.irqStatus[DEW_IRQ_DONE]  = s_nxt.irqStatus[DEW_IRQ_DONE]  | evDone;
    s_nxt.irqStatus[DEW_IRQ_ERR]   = s_nxt.irqStatus[DEW_IRQ_ERR]   | evErr;
    s_nxt.irqStatus[DEW_IRQ_ABORT] = s_nxt.irqStatus[DEW_IRQ_ABORT] | evAbort;
  end

  // ==========================================================================
  // Registers; reset also returns cells to the erased value
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ==========================================================================
  // Outputs; latch contents have no path to readdata
  assign avReadData    = s_r.rdata;
  assign avWaitRequest = (avReq.read | avReq.write) & ~s_r.ack;
  assign irq           = |(s_r.irqStatus & s_r.irqMask);
  assign programBusy   = s_r.programStart;
  assign eeWaitState   = (s_r.pwr == DEW_PWR_WAIT);
  assign eeHaltState   = (s_r.pwr == DEW_PWR_HALT);

endmodule

//--- logic/dew_pkg.sv
// Package of constants and types for the data EEPROM write controller
package dew_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned DEW_ADDR_W   = 11;
  localparam int unsigned DEW_CELLS    = 256;
  localparam int unsigned DEW_LATCHES  = 32;
  localparam int unsigned DEW_ROW_W    = 3;
  localparam int unsigned DEW_COL_W    = 5;
  localparam int unsigned DEW_IDX_W    = 8;
  localparam logic [7:0]  DEW_ERASED   = 8'h00;

  // ==========================================================================
  // Byte addresses on the bus
  localparam logic [DEW_ADDR_W-1:0] DEW_OFS_CTRL   = 11'h400;
  localparam logic [DEW_ADDR_W-1:0] DEW_OFS_IRQST  = 11'h404;
  localparam logic [DEW_ADDR_W-1:0] DEW_OFS_IRQMSK = 11'h408;
  localparam logic [DEW_ADDR_W-1:0] DEW_OFS_STAT   = 11'h40C;
  localparam int unsigned           DEW_AREA_BIT   = 10;

  // ==========================================================================
  // Field positions
  localparam int unsigned DEW_CTRL_PGM  = 0;
  localparam int unsigned DEW_CTRL_LAT  = 1;
  localparam int unsigned DEW_IRQ_W     = 3;
  localparam int unsigned DEW_IRQ_DONE  = 0;
  localparam int unsigned DEW_IRQ_ERR   = 1;
  localparam int unsigned DEW_IRQ_ABORT = 2;
  localparam int unsigned DEW_STAT_WAIT = 0;
  localparam int unsigned DEW_STAT_HALT = 1;
  localparam int unsigned DEW_STAT_WPO  = 2;
  localparam int unsigned DEW_STAT_RPO  = 3;

  // ==========================================================================
  // Timing
  localparam int unsigned DEW_CLK_KHZ      = 40000;
  localparam int unsigned DEW_PROG_TIME_US = 5000;
  localparam int unsigned DEW_PROG_CYCLES  = DEW_PROG_TIME_US * DEW_CLK_KHZ / 1000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0]
  {
    DEW_PWR_RUN  = 2'b00,
    DEW_PWR_WAIT = 2'b01,
    DEW_PWR_HALT = 2'b10
  } dew_pwr_e;

  typedef struct packed
  {
    logic                  read;
    logic                  write;
    logic [DEW_ADDR_W-1:0] address;
    logic [3:0]            byteenable;
    logic [31:0]           writedata;
  } dew_avreq_s;

  typedef struct packed
  {
    logic waitReq;
    logic haltReq;
  } dew_pwrreq_s;

endpackage

//--- tb/dew_eeprom_ctrl_properties.sv
// Checker of bus, programming and power relations
`timescale 1ns/100ps
module dew_eeprom_checker
  import dew_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 20
)
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Bus and requests
  input wire dew_avreq_s  avReq,
  input wire logic [31:0] avReadData,
  input wire logic        avWaitRequest,
  input wire dew_pwrreq_s pwrReq,
  input wire logic        readoutProtectOption,
  input wire logic        writeProtectOption,
  // Status
  input wire logic        irq,
  input wire logic        programBusy,
  input wire logic        eeWaitState,
  input wire logic        eeHaltState
);
  localparam int BusyMax = PROG_CYCLES + 4;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ====================
  // Bus
  a_one_wait_state: assert property ((avReq.read || avReq.write) && avWaitRequest |=> !avWaitRequest)
    else $error("request not answered after one wait state");
  a_upper_bytes_zero: assert property (avReq.read && !avWaitRequest |-> avReadData[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  // ====================
  // Programming cycle
  a_cycle_bounded: assert property ($rose(programBusy) |-> ##[1:BusyMax] !programBusy)
    else $error("programming cycle never ends");
  a_cycle_min_len: assert property ($rose(programBusy) ##1 (!pwrReq.haltReq)[*7] |-> programBusy)
    else $error("programming cycle ended too early");
  a_erase_aborts: assert property ($fell(readoutProtectOption) |=> !programBusy)
    else $error("protection removal did not stop programming");
  a_reset_clears: assert property (disable iff (1'b0) !rst_n |=> !programBusy && !irq && !eeWaitState)
    else $error("reset left state set");
  // ====================
  // Power states
  a_halt_aborts: assert property (pwrReq.haltReq && !eeWaitState && !eeHaltState |=> eeHaltState && !programBusy)
    else $error("halt not entered at once");
  a_wait_entry: assert property (pwrReq.waitReq && !pwrReq.haltReq && !programBusy && !eeWaitState && !eeHaltState
    |=> eeWaitState)
    else $error("wait not entered while idle");
  a_wait_not_busy: assert property ($rose(eeWaitState) |-> !$past(programBusy))
    else $error("wait entered during programming");
  c_program: cover property ($fell(programBusy));
  c_wait: cover property ($rose(eeWaitState));
  c_halt: cover property ($rose(eeHaltState));
endmodule

bind dew_eeprom_ctrl dew_eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk
(
  .clk_sys(clk_sys), .rst_n(rst_n), .avReq(avReq), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
  .pwrReq(pwrReq), .readoutProtectOption(readoutProtectOption), .writeProtectOption(writeProtectOption),
  .irq(irq), .programBusy(programBusy), .eeWaitState(eeWaitState), .eeHaltState(eeHaltState)
);

//--- tb/dew_cpu_model.sv
// Bus master model of the CPU core
`timescale 1ns/100ps
module dew_cpu_model
  import dew_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Avalon-MM master
  output dew_avreq_s       avReq,
  input  wire logic [31:0] avReadData,
  input  wire logic        avWaitRequest
);
  initial avReq = '0;
  // ====================
  // One transfer; waitrequest judged mid-cycle so the edge never races
  task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d, output logic [31:0] q);
    logic done;
    done = 1'b0;
    avReq <= '{read: !w, write: w, address: a, byteenable: 4'h1, writedata: {24'h0, d}};
    while (!done)
    begin
      @(negedge clk_sys);
      done = !avWaitRequest;
      @(posedge clk_sys);
    end
    q = avReadData;
    avReq <= '0;
    @(posedge clk_sys);
  endtask
endmodule

//--- tb/dew_eeprom_ctrl_test.sv
// Self-checking bench for the data EEPROM write controller
`timescale 1ns/100ps
module dew_eeprom_ctrl_test;
  import dew_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        readoutOpt = 1'b1;
  logic        writeOpt = 1'b0;
  dew_pwrreq_s pwrReq = '0;
  dew_avreq_s  avReq;
  logic [31:0] avReadData;
  logic        avWaitRequest, irq, programBusy, eeWaitState, eeHaltState;
  int          num_errors = 0;
  int          total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  dew_eeprom_ctrl #(.PROG_CYCLES(20)) u_dut
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .avReq(avReq), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .pwrReq(pwrReq), .readoutProtectOption(readoutOpt), .writeProtectOption(writeOpt), .irq(irq),
    .programBusy(programBusy), .eeWaitState(eeWaitState), .eeHaltState(eeHaltState)
  );
  dew_cpu_model u_cpu
  (
    .clk_sys(clk_sys), .avReq(avReq), .avReadData(avReadData), .avWaitRequest(avWaitRequest)
  );
  // ====================
  // Helpers
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    logic [31:0] q;
    u_cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    logic [31:0] q;
    u_cpu.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("read %h", a), q, {24'h0, e});
  endtask
  task automatic waitIdle;
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (programBusy !== 1'b0 && n < 60);
    chk("busy end", 32'(programBusy), 32'h0);
    @(posedge clk_sys);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ====================
  // Watchdog, far beyond the expected few hundred cycles
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    num_errors++;
    finish_test;
  end
  // ====================
  // Sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(DEW_OFS_CTRL, 8'h00);
    rd(11'h000, 8'h00);
    rd(11'h410, 8'h00);
    wr(DEW_OFS_IRQMSK, 8'h07);
    wr(11'h004, 8'h5A);
    rd(DEW_OFS_IRQST, 8'h02);
    chk("irq", 32'(irq), 32'h1);
    wr(DEW_OFS_IRQST, 8'h07);
    wr(DEW_OFS_CTRL, 8'h02);
    rd(DEW_OFS_CTRL, 8'h02);
    wr(11'h080, 8'hF3);
    wr(11'h080, 8'h3F);
    wr(11'h0FC, 8'hA5);
    rd(11'h080, 8'h00);
    rd(DEW_OFS_IRQST, 8'h02);
    writeOpt <= 1'b1;
    wr(DEW_OFS_IRQST, 8'h07);
    wr(DEW_OFS_CTRL, 8'h03);
    wr(DEW_OFS_CTRL, 8'h01);
    rd(DEW_OFS_CTRL, 8'h03);
    waitIdle;
    rd(DEW_OFS_CTRL, 8'h00);
    rd(DEW_OFS_IRQST, 8'h01);
    rd(11'h080, 8'h33);
    rd(11'h0FC, 8'hA5);
    rd(11'h004, 8'h00);
    rd(11'h084, 8'h00);
    wr(DEW_OFS_CTRL, 8'h02);
    wr(11'h100, 8'h77);
    wr(DEW_OFS_CTRL, 8'h00);
    wr(DEW_OFS_CTRL, 8'h03);
    waitIdle;
    rd(11'h100, 8'h00);
    wr(DEW_OFS_CTRL, 8'h02);
    wr(11'h000, 8'h11);
    wr(DEW_OFS_CTRL, 8'h03);
    pwrReq.waitReq <= 1'b1;
    @(negedge clk_sys);
    chk("wait busy", 32'(eeWaitState), 32'h0);
    waitIdle;
    @(negedge clk_sys);
    chk("wait idle", 32'(eeWaitState), 32'h1);
    @(posedge clk_sys);
    rd(11'h000, 8'h11);
    pwrReq.waitReq <= 1'b0;
    readoutOpt <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(11'h000, 8'h00);
    wr(DEW_OFS_IRQST, 8'h07);
    wr(DEW_OFS_CTRL, 8'h02);
    wr(11'h020, 8'h22);
    wr(DEW_OFS_CTRL, 8'h03);
    pwrReq.haltReq <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("halt", {eeHaltState, programBusy}, 32'h2);
    @(posedge clk_sys);
    pwrReq.haltReq <= 1'b0;
    rd(DEW_OFS_IRQST, 8'h04);
    wr(DEW_OFS_CTRL, 8'h02);
    wr(11'h040, 8'h99);
    wr(DEW_OFS_CTRL, 8'h03);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reset busy", 32'(programBusy), 32'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(DEW_OFS_CTRL, 8'h00);
    finish_test;
  end
endmodule
